// >>> dv/tape_drive_model.sv
// behavioural tape playback drive for one track link
`timescale 1ns/1ps
`default_nettype none

module tape_drive_model (
    // link pins toward the block
    output var logic track_clk_pin,
    output var logic track_bit_pin,
    output var logic sync_found_pin
);
    // ****************
    // link tasks
    // ****************
    // clock stands still low outside frames
    initial begin
        track_clk_pin = 1'b0;
        track_bit_pin = 1'b0;
        sync_found_pin = 1'b0;
    end

    // one bit, stable for half a period either side of the rise
    task automatic send_bit(input logic b);
        track_bit_pin = b;
        #160 track_clk_pin = 1'b1;
        #160 track_clk_pin = 1'b0;
    endtask

    // detector pulse at the end of the sync word, clock held still
    task automatic send_sync();
        #160 sync_found_pin = 1'b1;
        #320 sync_found_pin = 1'b0;
        #160;
    endtask

    // idle line must not show the last bit again
    task automatic go_idle();
        track_bit_pin = ~track_bit_pin;
    endtask
endmodule // tape_drive_model

`default_nettype wire

// >>> dv/tb.sv
// self-checking bench for the track frame buffer control
`timescale 1ns/1ps
`default_nettype none

module tb;
    // ****************
    // stimulus and hookup
    // ****************
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [12:0] frame_len = 13'h0800;
    logic [5:0] hdr_len = 6'h10;
    logic [15:0] next_frame_addr = 16'h0000;
    logic frame_valid_in = 1'b1;
    logic hdr_rd_req = 1'b0;
    logic [15:0] hdr_rd_addr = 16'h0000;
    logic hdr_sel = 1'b0;
    logic data_rd_req = 1'b0;
    wire track_clk_pin, track_bit_pin, sync_found_pin;
    wire [3:0] hdr_bus_data, data_nibble;
    wire hdr_bus_oe, hdr_rd_done, data_valid, frame_ok, frame_boundary, roll_sync;
    wire sync_mismatch, sync_jam, overrun;
    int n_fail = 0;
    int samples_checked = 0;
    int n_jam = 0;
    int n_slip = 0;
    int n_data = 0;
    int n_bound = 0;
    int n_over = 0;
    int hdr_left = 0;
    logic q[$];

    always #20 clk = ~clk;

    // pulse counters, sampled where the outputs are settled
    always @(posedge clk) begin
        n_jam += (sync_jam === 1'b1);
        n_slip += (sync_mismatch === 1'b1);
        n_data += (data_valid === 1'b1);
        n_bound += (frame_boundary === 1'b1);
        n_over += (overrun === 1'b1);
    end

    tape_drive_model u_tape_drive_model (
        .track_clk_pin(track_clk_pin), .track_bit_pin(track_bit_pin),
        .sync_found_pin(sync_found_pin)
    );

    track_frame_buffer_control u_track_frame_buffer_control (
        .clk(clk), .rst(rst), .track_clk_pin(track_clk_pin), .track_bit_pin(track_bit_pin),
        .sync_found_pin(sync_found_pin), .frame_len(frame_len), .hdr_len(hdr_len),
        .next_frame_addr(next_frame_addr), .frame_valid_in(frame_valid_in),
        .hdr_rd_req(hdr_rd_req), .hdr_rd_addr(hdr_rd_addr), .hdr_sel(hdr_sel),
        .hdr_bus_data(hdr_bus_data), .hdr_bus_oe(hdr_bus_oe), .hdr_rd_done(hdr_rd_done),
        .data_rd_req(data_rd_req), .data_nibble(data_nibble), .data_valid(data_valid),
        .frame_ok(frame_ok), .frame_boundary(frame_boundary), .roll_sync(roll_sync),
        .sync_mismatch(sync_mismatch), .sync_jam(sync_jam), .overrun(overrun)
    );

    // ****************
    // shared tasks
    // ****************
    task automatic check(input logic [3:0] got, input logic [3:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch at %0t ns: got %h expected %h", $time, got, exp);
        end
    endtask

    // sync lands at byte 12; header length clamps to 16..32
    task automatic start_frame();
        u_tape_drive_model.send_sync();
        hdr_left = (hdr_len < 6'h10) ? 4 : (hdr_len > 6'h20) ? 20 : hdr_len - 12;
        q.delete();
    endtask

    // msb first, parity last; parity kept only inside the header
    task automatic send_byte(input logic [8:0] b);
        for (int i = 8; i >= 0; i--) begin
            u_tape_drive_model.send_bit(b[i]);
            if (hdr_left > 0 || i != 0) q.push_back(b[i]);
        end
        if (hdr_left > 0) hdr_left--;
    endtask

    // request held until done, then dropped before the next edge, so no extra grant follows
    task automatic hdr_read(input logic [15:0] addr, input logic sel);
        int k;
        k = 0;
        hdr_rd_req = 1'b1;
        hdr_rd_addr = addr;
        hdr_sel = sel;
        do begin
            @(posedge clk);
            #1;
            k++;
        end while (hdr_rd_done !== 1'b1 && k < 10);
        check(hdr_rd_done, 1'b1);
        check(hdr_bus_oe, sel);
        hdr_rd_req = 1'b0;
        @(posedge clk);
        #1;
    endtask

    // stored bits come back four to a word, first bit in bit 3
    task automatic check_ram(input logic [15:0] base, input int n);
        logic [3:0] exp;
        for (int i = 0; i < n; i++) begin
            exp = {q[0], q[1], q[2], q[3]};
            repeat (4) void'(q.pop_front());
            hdr_read(base + i[15:0], i[0]);
            check(hdr_bus_data, exp);
        end
    endtask

    task automatic settle_link();
        u_tape_drive_model.go_idle();
        repeat (10) @(posedge clk);
        #1;
    endtask

    // ****************
    // scenarios
    // ****************
    // no frame captured yet: the data port gives nothing
    task automatic t_idle_refuse();
        n_data = 0;
        data_rd_req = 1'b1;
        repeat (20) @(posedge clk);
        #1;
        check(n_data[3:0], 4'h0);
        check(n_jam[3:0], 4'h0);
    endtask

    // header below minimum length, parity set on every data byte
    task automatic t_jam_pack();
        logic [8:0] pat[7] = '{9'h1A5, 9'h0C3, 9'h15E, 9'h07F, 9'h14F, 9'h079, 9'h0BD};
        next_frame_addr = 16'h1230;
        hdr_len = 6'h05;
        n_jam = 0;
        n_data = 0;
        n_bound = 0;
        n_over = 0;
        start_frame();
        // first sync lands off the prediction; no later slip may follow it
        n_slip = 0;
        foreach (pat[i]) send_byte(pat[i]);
        settle_link();
        check(n_jam[3:0], 4'h1);
        check(n_slip[3:0], 4'h0);
        check(n_over[3:0], 4'h0);
        // data port pops the frame start, then reads the six data nibbles
        check(n_bound[3:0], 4'h1);
        check(frame_ok, 1'b1);
        check(n_data[3:0], 4'h6);
        check(data_nibble, 4'hE);
        data_rd_req = 1'b0;
        check_ram(16'h1230, 15);
    endtask

    // sync in mid data realigns to a new address and a longer header
    task automatic t_resync();
        logic [8:0] pat[6] = '{9'h1C3, 9'h0A6, 9'h13C, 9'h0F0, 9'h1E1, 9'h0B5};
        next_frame_addr = 16'h4000;
        hdr_len = 6'h11;
        send_byte(9'h155);
        n_jam = 0;
        n_slip = 0;
        start_frame();
        foreach (pat[i]) send_byte(pat[i]);
        settle_link();
        check(n_jam[3:0], 4'h1);
        check(n_slip[3:0], 4'h1);
        // slip seen: the processor marks the frame after it, judgement held until now
        frame_valid_in = 1'b0;
        check_ram(16'h4000, 13);
    endtask

    // ****************
    // run control
    // ****************
    task automatic wrap_up();
        $display("checks %0d, mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    initial begin
        repeat (10) @(posedge clk);
        #1;
        rst = 1'b0;
        repeat (3) @(posedge clk);
        #1;
        t_idle_refuse();
        t_jam_pack();
        t_resync();
        wrap_up();
    end

    // the whole run needs about 42 us of link traffic
    initial begin
        #200000;
        n_fail++;
        wrap_up();
    end
endmodule // tb

`default_nettype wire

// >>> dv/track_frame_buffer_control_props.sv
// concurrent checks on the track frame buffer control ports
`timescale 1ns/1ps
`default_nettype none

module track_frame_buffer_control_props #(
    parameter ADDR_W = 16,
    parameter NIB_W = 4
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // link pins
    input wire logic track_clk_pin,
    input wire logic track_bit_pin,
    input wire logic sync_found_pin,
    // format and processor controls
    input wire logic [12:0] frame_len,
    input wire logic [5:0] hdr_len,
    input wire logic [ADDR_W-1:0] next_frame_addr,
    input wire logic frame_valid_in,
    // header port
    input wire logic hdr_rd_req,
    input wire logic [ADDR_W-1:0] hdr_rd_addr,
    input wire logic hdr_sel,
    input wire logic [NIB_W-1:0] hdr_bus_data,
    input wire logic hdr_bus_oe,
    input wire logic hdr_rd_done,
    // data port
    input wire logic data_rd_req,
    input wire logic [NIB_W-1:0] data_nibble,
    input wire logic data_valid,
    input wire logic frame_ok,
    input wire logic frame_boundary,
    input wire logic roll_sync,
    // status
    input wire logic sync_mismatch,
    input wire logic sync_jam,
    input wire logic overrun
);
    // ****************
    // checks
    // ****************
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    // status outputs are single-cycle pulses
    sequence s_jam_once;
        sync_jam ##1 !sync_jam;
    endsequence
    sequence s_slip_once;
        sync_mismatch ##1 !sync_mismatch;
    endsequence

    chk_jam_cause: assert property (sync_jam |-> $past(sync_found_pin, 3) && !$past(sync_found_pin, 4))
        else $error("jam without sync detection");
    chk_jam_pulse: assert property (sync_jam |-> s_jam_once)
        else $error("jam pulse too long");
    chk_slip_pulse: assert property (sync_mismatch |-> s_slip_once)
        else $error("mismatch pulse too long");
    chk_done_cause: assert property (hdr_rd_done |-> $past(hdr_rd_req))
        else $error("header done without request");
    chk_oe_select: assert property (hdr_rd_done |-> hdr_bus_oe == $past(hdr_sel))
        else $error("bus enable not following select");
    chk_oe_quiet: assert property (!hdr_rd_done |-> !hdr_bus_oe)
        else $error("bus driven with no read");
    chk_grant_wait: assert property ($rose(hdr_rd_req) |-> ##[1:6] hdr_rd_done)
        else $error("header read starved");
    chk_roll_align: assert property (roll_sync == frame_boundary)
        else $error("roll resync off frame boundary");
    chk_ok_steady: assert property (!frame_boundary |-> $stable(frame_ok))
        else $error("validity moved inside a frame");
    chk_data_cause: assert property (data_valid |-> $past(data_rd_req) && !$past(hdr_rd_req))
        else $error("data read without a free slot");
    chk_skip_slot: assert property (frame_boundary |-> !data_valid)
        else $error("data on frame start slot");
endmodule // track_frame_buffer_control_props

bind track_frame_buffer_control track_frame_buffer_control_props #(
    .ADDR_W(ADDR_W), .NIB_W(NIB_W)
) u_props (
    .clk(clk), .rst(rst), .track_clk_pin(track_clk_pin), .track_bit_pin(track_bit_pin),
    .sync_found_pin(sync_found_pin), .frame_len(frame_len), .hdr_len(hdr_len),
    .next_frame_addr(next_frame_addr), .frame_valid_in(frame_valid_in),
    .hdr_rd_req(hdr_rd_req), .hdr_rd_addr(hdr_rd_addr), .hdr_sel(hdr_sel),
    .hdr_bus_data(hdr_bus_data), .hdr_bus_oe(hdr_bus_oe), .hdr_rd_done(hdr_rd_done),
    .data_rd_req(data_rd_req), .data_nibble(data_nibble), .data_valid(data_valid),
    .frame_ok(frame_ok), .frame_boundary(frame_boundary), .roll_sync(roll_sync),
    .sync_mismatch(sync_mismatch), .sync_jam(sync_jam), .overrun(overrun)
);

`default_nettype wire

// >>> rtl/nibble_fifo.v
// small first-in first-out buffer between capture and ram write
`timescale 1ns/1ps
`default_nettype none

module nibble_fifo #(
    parameter WIDTH = 20,
    parameter DEPTH = 4,
    parameter PTR_W = 2
) (
    // clock and reset
    input wire clk,
    input wire rst,
    // filling side
    input wire in_valid,
    output wire in_ready,
    input wire [WIDTH-1:0] in_data,
    // draining side
    output wire out_valid,
    input wire out_ready,
    output wire [WIDTH-1:0] out_data
);

    reg [WIDTH-1:0] store [0:DEPTH-1];
    reg [PTR_W-1:0] wr_ptr;
    reg [PTR_W-1:0] rd_ptr;
    reg [PTR_W:0] count;

    wire push = in_valid && in_ready;
    wire pop = out_valid && out_ready;

    assign in_ready = (count != DEPTH[PTR_W:0]);
    assign out_valid = (count != {(PTR_W+1){1'b0}});
    assign out_data = store[rd_ptr];

    // storage has no reset, only pointers and count do
    always @(posedge clk) begin
        if (push) begin
            store[wr_ptr] <= in_data;
        end
    end

    // pointers wrap naturally since depth is a power of two
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            wr_ptr <= {PTR_W{1'b0}};
            rd_ptr <= {PTR_W{1'b0}};
            count <= {(PTR_W+1){1'b0}};
        end else begin
            if (push) begin
                wr_ptr <= wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= rd_ptr + 1'b1;
            end
            if (push && !pop) begin
                count <= count + 1'b1;
            end else if (pop && !push) begin
                count <= count - 1'b1;
            end
        end
    end

endmodule // nibble_fifo

`default_nettype wire

// >>> rtl/track_buffer_defs.vh
// constants shared by the track frame buffer control files
`ifndef TRACK_BUFFER_DEFS_VH
`define TRACK_BUFFER_DEFS_VH

// ****************************************************************
// tape format geometry
// ****************************************************************
`define BYTE_LAST_BIT 4'h8
`define NIBBLE_LAST 2'h3
`define FRAME_BYTES_MIN 13'h0800
`define FRAME_BYTES_MAX 13'h1000
`define HEADER_BYTES_MIN 6'h10
`define HEADER_BYTES_MAX 6'h20
`define SYNC_WORD_BITS 6'h24
`define SYNC_WORD_BYTES 13'h0004
`define SYNC_END_BYTE 13'h000C

// ****************************************************************
// buffer geometry
// ****************************************************************
`define RAM_ADDR_W 16
`define NIBBLE_W 4
`define FIFO_DEPTH 4
`define FRAME_TAB_DEPTH 4
`define FRAME_TAB_PTR_W 2

`endif

// >>> rtl/track_frame_buffer_control.v
// frame buffer ram control for one playback track
`timescale 1ns/1ps
`default_nettype none
`include "track_buffer_defs.vh"

module track_frame_buffer_control #(
    parameter ADDR_W = `RAM_ADDR_W,
    parameter NIB_W = `NIBBLE_W
) (
    // clock and reset
    input wire clk,
    input wire rst,
    // track link pins from the tape playback drive
    input wire track_clk_pin,
    input wire track_bit_pin,
    input wire sync_found_pin,
    // tape format and processor controls
    input wire [12:0] frame_len,
    input wire [5:0] hdr_len,
    input wire [ADDR_W-1:0] next_frame_addr,
    input wire frame_valid_in,
    // header read port, shared bus
    input wire hdr_rd_req,
    input wire [ADDR_W-1:0] hdr_rd_addr,
    input wire hdr_sel,
    output reg [NIB_W-1:0] hdr_bus_data,
    output reg hdr_bus_oe,
    output reg hdr_rd_done,
    // track data read port
    input wire data_rd_req,
    output reg [NIB_W-1:0] data_nibble,
    output reg data_valid,
    output reg frame_ok,
    output reg frame_boundary,
    output reg roll_sync,
    // status toward the processor
    output reg sync_mismatch,
    output reg sync_jam,
    output reg overrun
);

    // ****************************************************************
    // pin synchronisation
    // ****************************************************************
    wire [2:0] pin_level;
    wire [2:0] pin_rise;

    // link clock is only sampled; nothing is clocked by it
    write_request_synchroniser #(
        .WIDTH(3)
    ) u_pins (
        .clk(clk),
        .rst(rst),
        .pin({sync_found_pin, track_bit_pin, track_clk_pin}),
        .level(pin_level),
        .rise(pin_rise)
    );

    wire bit_edge = pin_rise[0];
    wire bit_val = pin_level[1];
    wire sync_det = pin_rise[2];

    // ****************************************************************
    // format limits
    // ****************************************************************
    reg [12:0] frame_eff;
    reg [12:0] hdr_eff;

    // out-of-range settings are clamped rather than trusted
    always @* begin
        if (frame_len < `FRAME_BYTES_MIN) begin
            frame_eff = `FRAME_BYTES_MIN;
        end else if (frame_len > `FRAME_BYTES_MAX) begin
            frame_eff = `FRAME_BYTES_MAX;
        end else begin
            frame_eff = frame_len;
        end
        if (hdr_len < `HEADER_BYTES_MIN) begin
            hdr_eff = {7'h00, `HEADER_BYTES_MIN};
        end else if (hdr_len > `HEADER_BYTES_MAX) begin
            hdr_eff = {7'h00, `HEADER_BYTES_MAX};
        end else begin
            hdr_eff = {7'h00, hdr_len};
        end
    end

    // ****************************************************************
    // bit capture and nibble packing
    // ****************************************************************
    reg [3:0] bit_cnt;
    reg [12:0] byte_cnt;
    reg [1:0] nib_cnt;
    reg [NIB_W-1:0] shreg;
    reg [ADDR_W-1:0] wr_addr;
    reg pred_armed;
    reg hold_full;
    reg [NIB_W-1:0] hold_data;
    reg [ADDR_W-1:0] hold_addr;
    reg frame_new;
    reg data_new;
    reg [ADDR_W-1:0] hdr_pend;
    reg tab_push;
    reg [2*ADDR_W-1:0] tab_entry;
    wire fifo_in_ready;

    wire in_header = (byte_cnt < hdr_eff);
    wire parity_bit = (bit_cnt == `BYTE_LAST_BIT);
    wire keep_bit = in_header || !parity_bit;
    wire nib_done = keep_bit && (nib_cnt == `NIBBLE_LAST);
    wire at_pred = (byte_cnt == `SYNC_END_BYTE) && (bit_cnt == 4'h0);
    wire byte_end = parity_bit;
    wire frame_end = byte_end && (byte_cnt == frame_eff - 13'h0001);

    // sync word is four bytes, so its end byte sits past the header start
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            bit_cnt <= 4'h0;
            byte_cnt <= 13'h0000;
            nib_cnt <= 2'h0;
            shreg <= 4'h0;
            wr_addr <= {ADDR_W{1'b0}};
            pred_armed <= 1'b0;
            hold_full <= 1'b0;
            hold_data <= 4'h0;
            hold_addr <= {ADDR_W{1'b0}};
            frame_new <= 1'b0;
            data_new <= 1'b0;
            hdr_pend <= {ADDR_W{1'b0}};
            tab_push <= 1'b0;
            tab_entry <= {(2*ADDR_W){1'b0}};
            sync_mismatch <= 1'b0;
            sync_jam <= 1'b0;
            overrun <= 1'b0;
        end else begin
            sync_mismatch <= 1'b0;
            sync_jam <= 1'b0;
            overrun <= 1'b0;
            tab_push <= 1'b0;
            // holding register drains once the fifo accepts it
            if (hold_full && fifo_in_ready) begin
                hold_full <= 1'b0;
            end
            if (sync_det) begin
                // detected sync away from the predicted spot is a slip
                sync_mismatch <= !at_pred;
                sync_jam <= 1'b1;
                pred_armed <= 1'b0;
                bit_cnt <= 4'h0;
                byte_cnt <= `SYNC_END_BYTE;
                nib_cnt <= 2'h0;
                wr_addr <= next_frame_addr;
            end else if (bit_edge) begin
                // predicted sync passed with no detection: missed sync
                if (pred_armed) begin
                    sync_mismatch <= 1'b1;
                    pred_armed <= 1'b0;
                end
                if (keep_bit) begin
                    shreg <= {shreg[2:0], bit_val};
                    nib_cnt <= nib_cnt + 2'h1;
                end
                if (nib_done) begin
                    // a late drain means the older nibble is overwritten
                    overrun <= hold_full && !fifo_in_ready;
                    hold_full <= 1'b1;
                    hold_data <= {shreg[2:0], bit_val};
                    hold_addr <= wr_addr;
                    wr_addr <= wr_addr + 1'b1;
                    if (frame_new) begin
                        hdr_pend <= wr_addr;
                        frame_new <= 1'b0;
                    end
                    if (data_new) begin
                        tab_push <= 1'b1;
                        tab_entry <= {hdr_pend, wr_addr};
                        data_new <= 1'b0;
                    end
                end
                if (byte_end) begin
                    bit_cnt <= 4'h0;
                    if (frame_end) begin
                        byte_cnt <= 13'h0000;
                        frame_new <= 1'b1;
                    end else begin
                        byte_cnt <= byte_cnt + 13'h0001;
                        // arm only when counting into the predicted spot, never after a jam
                        if (byte_cnt + 13'h0001 == `SYNC_END_BYTE) begin
                            pred_armed <= 1'b1;
                        end
                        if (byte_cnt + 13'h0001 == hdr_eff) begin
                            data_new <= 1'b1;
                        end
                    end
                end else begin
                    bit_cnt <= bit_cnt + 4'h1;
                end
            end
        end
    end

    // ****************************************************************
    // write path buffer
    // ****************************************************************
    wire fifo_out_valid;
    wire [ADDR_W+NIB_W-1:0] fifo_out_data;

    nibble_fifo #(
        .WIDTH(ADDR_W + NIB_W),
        .DEPTH(`FIFO_DEPTH),
        .PTR_W(2)
    ) u_fifo (
        .clk(clk),
        .rst(rst),
        .in_valid(hold_full),
        .in_ready(fifo_in_ready),
        .in_data({hold_addr, hold_data}),
        .out_valid(fifo_out_valid),
        .out_ready(1'b1),
        .out_data(fifo_out_data)
    );

    // ****************************************************************
    // frame start table
    // ****************************************************************
    reg [2*ADDR_W-1:0] ftab [0:`FRAME_TAB_DEPTH-1];
    reg [`FRAME_TAB_PTR_W-1:0] tab_wp;
    reg [`FRAME_TAB_PTR_W-1:0] tab_rp;
    reg [`FRAME_TAB_PTR_W:0] tab_cnt;
    wire tab_pop;

    wire tab_full = (tab_cnt == `FRAME_TAB_DEPTH);
    wire tab_empty = (tab_cnt == 3'h0);
    wire [ADDR_W-1:0] tab_hdr = ftab[tab_rp][2*ADDR_W-1:ADDR_W];
    wire [ADDR_W-1:0] tab_data = ftab[tab_rp][ADDR_W-1:0];
    wire tab_wr = tab_push && !tab_full;

    // a full table drops the newest frame start; readout then runs through it
    always @(posedge clk) begin
        if (tab_wr) begin
            ftab[tab_wp] <= tab_entry;
        end
    end

    always @(posedge clk or posedge rst) begin
        if (rst) begin
            tab_wp <= 2'h0;
            tab_rp <= 2'h0;
            tab_cnt <= 3'h0;
        end else begin
            if (tab_wr) begin
                tab_wp <= tab_wp + 2'h1;
            end
            if (tab_pop) begin
                tab_rp <= tab_rp + 2'h1;
            end
            if (tab_wr && !tab_pop) begin
                tab_cnt <= tab_cnt + 3'h1;
            end else if (tab_pop && !tab_wr) begin
                tab_cnt <= tab_cnt - 3'h1;
            end
        end
    end

    // ****************************************************************
    // ram and arbitration
    // ****************************************************************
    reg [NIB_W-1:0] mem [0:(1<<ADDR_W)-1];
    reg [ADDR_W-1:0] rd_addr;
    reg [ADDR_W-1:0] wr_tail;
    reg rd_started;

    // write always wins; header reads beat data reads
    wire grant_wr = fifo_out_valid;
    wire grant_hdr = hdr_rd_req && !grant_wr;
    wire data_slot = data_rd_req && !grant_wr && !grant_hdr;
    wire at_frame = !tab_empty && (!rd_started || rd_addr == tab_hdr);
    assign tab_pop = data_slot && at_frame;
    wire data_read = data_slot && !at_frame && rd_started && (rd_addr != wr_tail);

    always @(posedge clk) begin
        if (grant_wr) begin
            mem[fifo_out_data[ADDR_W+NIB_W-1:NIB_W]] <= fifo_out_data[NIB_W-1:0];
        end
    end

    // ****************************************************************
    // read ports
    // ****************************************************************
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            rd_addr <= {ADDR_W{1'b0}};
            wr_tail <= {ADDR_W{1'b0}};
            rd_started <= 1'b0;
            hdr_bus_data <= 4'h0;
            hdr_bus_oe <= 1'b0;
            hdr_rd_done <= 1'b0;
            data_nibble <= 4'h0;
            data_valid <= 1'b0;
            frame_ok <= 1'b0;
            frame_boundary <= 1'b0;
            roll_sync <= 1'b0;
        end else begin
            hdr_rd_done <= grant_hdr;
            hdr_bus_oe <= grant_hdr && hdr_sel;
            data_valid <= data_read;
            frame_boundary <= tab_pop;
            roll_sync <= tab_pop;
            if (grant_wr) begin
                wr_tail <= fifo_out_data[ADDR_W+NIB_W-1:NIB_W] + 1'b1;
            end
            if (grant_hdr) begin
                hdr_bus_data <= mem[hdr_rd_addr];
            end
            if (tab_pop) begin
                // header nibbles are jumped over at each frame start
                rd_addr <= tab_data;
                rd_started <= 1'b1;
                frame_ok <= frame_valid_in;
            end else if (data_read) begin
                data_nibble <= mem[rd_addr];
                rd_addr <= rd_addr + 1'b1;
            end
        end
    end

endmodule // track_frame_buffer_control

`default_nettype wire

// >>> rtl/write_request_synchroniser.v
// two-flop synchroniser with rising-edge pulse for pin inputs
`timescale 1ns/1ps
`default_nettype none

module write_request_synchroniser #(
    parameter WIDTH = 3
) (
    // clock and reset
    input wire clk,
    input wire rst,
    // asynchronous pins
    input wire [WIDTH-1:0] pin,
    // synchronised levels and rising edges
    output reg [WIDTH-1:0] level,
    output wire [WIDTH-1:0] rise
);

    reg [WIDTH-1:0] meta;
    reg [WIDTH-1:0] level_prev;

    // first stage feeds only the second stage
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            meta <= {WIDTH{1'b0}};
            level <= {WIDTH{1'b0}};
            level_prev <= {WIDTH{1'b0}};
        end else begin
            meta <= pin;
            level <= meta;
            level_prev <= level;
        end
    end

    // edge found on the settled copy only
    assign rise = level & ~level_prev;

endmodule // write_request_synchroniser

`default_nettype wire
